// [gtps_slicer.sv]
// gear-tooth peak/valley slicer core with lockout and startup order
//
// Operation
// R01: track and hold peak and valley levels
// R02: slice input at mean of peak, valley
// R03: rising output raises valley by span/4
// R04: falling output lowers peak by span/4
// R05: preload computed from counter contents
// R06: peak counts up while input exceeds it
// R07: valley counts down while input below it
// R08: reset stops tracking and output switching
// R09: output high through reset until first fall
// R10: enable switching above upper span threshold
// R11: disable switching below lower span threshold
// R12: reset, settle tracking, then lockout release
// R13: all decisions on one sample clock
// R14: lockout thresholds are counter-unit parameters
//
// behaviour in short
// - the sample is synchronised by two flops before any use
// - the input must move slowly against the clock: each bit is
//   synchronised on its own, so a fast-changing word may be seen
//   torn for one cycle, nudge a counter by one step and, in the run state, trip a false crossing with its preload
// - peak and valley move one count per cycle, so full tracking
//   of a large step takes up to a full counter range of cycles
// - the output only follows crossings in the run state; the power-on indication forces it high in any state
// - a preload wins over a count step in the same cycle
// - counter arithmetic wraps; the preload can never pass the
//   opposite counter because it is a quarter of the span
// - the power-on indication freezes the trackers but keeps
//   their contents, so tracking resumes from the held levels
//
// limitations
// - thresholds compare the counter span only, not field units
// - the settle time is a cycle count, scaled to the clock
`timescale 1ns/10ps
module gtps_slicer
  import gtps_pkg::*;
#(
  parameter gtps_sample_t LOCK_ON   = `GTPS_LOCK_ON_CNT,
  parameter gtps_sample_t LOCK_OFF  = `GTPS_LOCK_OFF_CNT,
  parameter int unsigned  TRACK_CYC = `GTPS_TRACK_CYC
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         porActive,
  input  wire gtps_sample_t sampleIn,
  output logic              sliceOut,
  output gtps_hold_t        holdLevels,
  output logic              switchEn
);
  // ==========================================================
  // input synchronisers
  //
  // both the sample word and the power-on indication come from
  // outside this clock domain; the power-on flops reset to the
  // asserted level so nothing runs before the pin is seen low
  gtps_sample_t sampleMeta_r;
  gtps_sample_t sample_r;
  logic         porMeta_r;
  logic         por_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sampleMeta_r <= 12'h000;
      sample_r     <= 12'h000;
      porMeta_r    <= 1'b1;
      por_r        <= 1'b1;
    end else begin
      sampleMeta_r <= sampleIn;
      sample_r     <= sampleMeta_r;
      porMeta_r    <= porActive;
      por_r        <= porMeta_r;
    end
  end

  // ==========================================================
  // peak and valley trackers
  logic         runEn;
  logic         riseEdge;
  logic         fallEdge;
  gtps_sample_t peak;
  gtps_sample_t valley;
  gtps_sample_t span;
  gtps_sample_t quarter;
  gtps_sample_t slice;
  logic [12:0]  sum;

  // R05: preload from counters
  // span reads zero until the two trackers have crossed over,
  // which keeps the lockout closed right after start-up
  assign span    = (peak > valley) ? (peak - valley) : 12'h000;
  assign quarter = span >> `GTPS_PRELOAD_SHIFT;

  // R13: single sample clock
  // R06: peak counter up
  // R04: peak drops at fall
  gtps_tracker #(
    .UPWARD  (1'b1),
    .RST_VAL (`GTPS_PEAK_RST)
  ) u_peak (
    .clk        (clk),
    .reset_n    (reset_n),
    .runEn      (runEn),
    .sample     (sample_r),
    .preload    (fallEdge),
    .preloadAmt (quarter),
    .hold       (peak)
  );

  // R07: valley counter down
  // R03: valley rises at rise
  gtps_tracker #(
    .UPWARD  (1'b0),
    .RST_VAL (`GTPS_VALLEY_RST)
  ) u_valley (
    .clk        (clk),
    .reset_n    (reset_n),
    .runEn      (runEn),
    .sample     (sample_r),
    .preload    (riseEdge),
    .preloadAmt (quarter),
    .hold       (valley)
  );

  // R02: mean slicing level
  // one spare bit keeps the carry of the sum before halving
  assign sum   = {1'b0, peak} + {1'b0, valley};
  assign slice = sum[12:1];

  // ==========================================================
  // startup sequencer and lockout
  gtps_state_t  state_r;
  gtps_state_t  state_nxt;
  logic [31:0]  settleCnt_r;
  logic [31:0]  settleCnt_nxt;
  logic         out_r;
  logic         out_nxt;

  // R08: por halts everything
  // trackers run in settle, locked and run, never in reset
  assign runEn = !por_r && (state_r != GTPS_RESET);

  // R12: ordered startup stages
  // reset -> settle (fixed cycle count) -> locked -> run;
  // the power-on indication sends any stage back to reset
  always_comb begin
    state_nxt     = state_r;
    settleCnt_nxt = settleCnt_r;
    if (por_r) begin
      state_nxt     = GTPS_RESET;
      settleCnt_nxt = 32'h0000_0000;
    end else begin
      case (state_r)
        GTPS_RESET: begin
          state_nxt = GTPS_SETTLE;
        end
        GTPS_SETTLE: begin
          settleCnt_nxt = settleCnt_r + 32'h0000_0001;
          if (settleCnt_r >= TRACK_CYC - 1) begin
            state_nxt = GTPS_LOCKED;
          end
        end
        GTPS_LOCKED: begin
          // R10: upper lockout threshold
          if (span > LOCK_ON) begin
            state_nxt = GTPS_RUN;
          end
        end
        GTPS_RUN: begin
          // R11: lower lockout threshold
          // R14: thresholds in counts
          if (span < LOCK_OFF) begin
            state_nxt = GTPS_LOCKED;
          end
        end
        default: begin
          state_nxt = GTPS_RESET;
        end
      endcase
    end
  end

  // R09: output held high until first fall
  // while locked the output keeps its last level; a crossing
  // only counts in the run state
  always_comb begin
    out_nxt = out_r;
    if (por_r || state_r == GTPS_RESET) begin
      out_nxt = 1'b1;
    end else if (state_r == GTPS_RUN) begin
      if (out_r && sample_r < slice) begin
        out_nxt = 1'b0;
      end else if (!out_r && sample_r > slice) begin
        out_nxt = 1'b1;
      end
    end
  end

  // R03: edge pulses drive preload
  // the pulses come from the next output value, so the preload
  // lands on the same edge as the output change
  assign riseEdge = runEn && !out_r && out_nxt;
  assign fallEdge = runEn && out_r && !out_nxt;

  // sequencer and output registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r     <= GTPS_RESET;
      settleCnt_r <= 32'h0000_0000;
      out_r       <= 1'b1;
    end else begin
      state_r     <= state_nxt;
      settleCnt_r <= settleCnt_nxt;
      out_r       <= out_nxt;
    end
  end

  // ==========================================================
  // outputs
  //
  // R01: held levels visible
  assign holdLevels = '{peak: peak, valley: valley};

  // slicer output straight from its register
  assign sliceOut   = out_r;

  // lockout released only in the run state
  assign switchEn   = (state_r == GTPS_RUN);
endmodule

// [gtps_cfg.svh]
// constants for the gear-tooth peak/valley slicer
`ifndef GTPS_CFG_SVH
`define GTPS_CFG_SVH
`define GTPS_SAMPLE_W      12
`define GTPS_PEAK_RST      12'h000
`define GTPS_VALLEY_RST    12'hFFF
`define GTPS_PRELOAD_SHIFT 2
`define GTPS_LOCK_ON_CNT   12'h04D
`define GTPS_LOCK_OFF_CNT  12'h037
`define GTPS_CLK_MHZ       250
`define GTPS_TRACK_US      1000
`define GTPS_TRACK_CYC     (`GTPS_TRACK_US * `GTPS_CLK_MHZ)
`endif

// [gtps_pkg.sv]
// types for the gear-tooth peak/valley slicer
`include "gtps_cfg.svh"
package gtps_pkg;
  typedef logic [`GTPS_SAMPLE_W-1:0] gtps_sample_t;
  typedef struct packed {
    gtps_sample_t peak;
    gtps_sample_t valley;
  } gtps_hold_t;
  typedef enum logic [1:0] {GTPS_RESET, GTPS_SETTLE, GTPS_LOCKED, GTPS_RUN} gtps_state_t;
endpackage

// [gtps_tracker.sv]
// one peak or valley track-and-hold counter with edge preload
`timescale 1ns/10ps
module gtps_tracker
  import gtps_pkg::*;
#(
  parameter bit            UPWARD  = 1'b1,
  parameter logic [11:0]   RST_VAL = 12'h000
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         runEn,
  input  wire gtps_sample_t sample,
  input  wire logic         preload,
  input  wire gtps_sample_t preloadAmt,
  output gtps_sample_t      hold
);
  gtps_sample_t hold_r;
  gtps_sample_t hold_nxt;
  logic         beyond;

  // input past the held level in the tracked direction
  assign beyond = UPWARD ? (sample > hold_r) : (sample < hold_r);

  // step one count while beyond, preload toward the slice at edges
  always_comb begin
    hold_nxt = hold_r;
    if (runEn) begin
      if (preload) begin
        hold_nxt = UPWARD ? (hold_r - preloadAmt) : (hold_r + preloadAmt);
      end else if (beyond) begin
        hold_nxt = UPWARD ? (hold_r + 12'h001) : (hold_r - 12'h001);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hold_r <= RST_VAL;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  assign hold = hold_r;
endmodule

// [gtps_front_model.sv]
// front end model: presents the field level as one sample a cycle
`timescale 1ns/10ps
module gtps_front_model
  import gtps_pkg::*;
(
  input  wire logic         clk,
  input  wire gtps_sample_t level,
  output gtps_sample_t      sample
);
  always_ff @(posedge clk) begin
    sample <= level;
  end
endmodule

// [gtps_slicer_properties.sv]
// port assertions for the slicer
`timescale 1ns/10ps
module gtps_slicer_properties
  import gtps_pkg::*;
#(
  parameter gtps_sample_t LOCK_ON  = 12'h04D,
  parameter gtps_sample_t LOCK_OFF = 12'h037
) (
  input wire logic         clk,
  input wire logic         reset_n,
  input wire logic         porActive,
  input wire gtps_sample_t sampleIn,
  input wire logic         sliceOut,
  input wire gtps_hold_t   holdLevels,
  input wire logic         switchEn
);
  gtps_sample_t pk, vl, span;
  // span as the design measures it
  assign pk = holdLevels.peak;
  assign vl = holdLevels.valley;
  assign span = (pk > vl) ? pk - vl : 12'h000;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========
  // checks
  chk_rst_vals: assert property ($rose(reset_n) |-> sliceOut && !switchEn && holdLevels == 24'h000FFF)
    else $error("bad values at reset release");
  chk_fall_run: assert property ($fell(sliceOut) |-> $past(switchEn))
    else $error("output fell while locked out");
  chk_en_span: assert property ($rose(switchEn) |-> $past(span) > LOCK_ON)
    else $error("enabled on small span");
  chk_off_span: assert property ($fell(switchEn) |-> $past(span) < LOCK_OFF || $past(porActive, 2) || $past(porActive, 3))
    else $error("disabled on large span");
  chk_fall_pre: assert property ($fell(sliceOut) |-> pk == $past(pk) - ($past(span) >> 2))
    else $error("bad peak preload");
  // a rise forced by the power-on indication carries no preload
  chk_rise_pre: assert property ($rose(sliceOut) && $past(switchEn) && !$past(porActive, 2)
    |-> vl == $past(vl) + ($past(span) >> 2))
    else $error("bad valley preload");
  chk_pk_step: assert property (pk > $past(pk) |-> pk == $past(pk) + 12'h001)
    else $error("peak step not one");
  chk_vl_step: assert property (vl < $past(vl) |-> vl == $past(vl) - 12'h001)
    else $error("valley step not one");
  cov_fall: cover property ($fell(sliceOut));
  cov_rise: cover property ($rose(sliceOut) && switchEn);
  cov_off: cover property ($fell(switchEn));
endmodule

// [gtps_tb.sv]
// self-checking bench for the slicer
`timescale 1ns/10ps
module testbench;
  import gtps_pkg::*;
  typedef struct packed {gtps_sample_t lvl; gtps_hold_t hold; logic out; logic en;} gtps_row_t;
  logic         clk = 1'b0;
  logic         reset_n = 1'b0;
  logic         porActive = 1'b0;
  logic         sliceOut, switchEn, o;
  gtps_sample_t level = 12'h800;
  gtps_sample_t sampleIn;
  gtps_hold_t   holdLevels, kept;
  int           n_errors = 0;
  int           compares = 0;
  gtps_row_t    rows [6] = '{'{12'h800, 24'h800800, 1'b1, 1'b0}, '{12'h900, 24'h900800, 1'b1, 1'b1},
    '{12'h700, 24'h8C0700, 1'b0, 1'b1}, '{12'h900, 24'h900770, 1'b1, 1'b1},
    '{12'h780, 24'h89C770, 1'b0, 1'b1}, '{12'h900, 24'h9007BB, 1'b1, 1'b1}};
  // 250 MHz clock
  always #2 clk = ~clk;
  gtps_front_model FE (.clk(clk), .level(level), .sample(sampleIn));
  gtps_slicer #(.TRACK_CYC(10)) DUT (.clk(clk), .reset_n(reset_n), .porActive(porActive),
    .sampleIn(sampleIn), .sliceOut(sliceOut), .holdLevels(holdLevels), .switchEn(switchEn));
  task tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk_bit(logic a, logic e);
    compares++;
    if (a !== e) begin
      n_errors++;
      $display("Error %0t bit %0h exp %0h", $time, a, e);
    end
  endtask
  task chk_hold(gtps_hold_t a, gtps_hold_t e);
    compares++;
    if (a !== e) begin
      n_errors++;
      $display("Error %0t hold %0h exp %0h", $time, a, e);
    end
  endtask
  task final_report;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========
  // main sequence
  initial begin
    tick(16);
    chk_hold(holdLevels, 24'h000FFF);
    chk_bit(sliceOut, 1'b1);
    reset_n = 1'b1;
    foreach (rows[i]) begin
      level = rows[i].lvl;
      tick(i == 0 ? 3000 : 400);
      chk_hold(holdLevels, rows[i].hold);
      chk_bit(sliceOut, rows[i].out);
      chk_bit(switchEn, rows[i].en);
    end
    kept = holdLevels;
    porActive = 1'b1;
    tick(5);
    level = 12'hFFF;
    tick(20);
    chk_hold(holdLevels, kept);
    chk_bit(switchEn, 1'b0);
    chk_bit(sliceOut, 1'b1);
    level = 12'h900;
    tick(10);
    porActive = 1'b0;
    tick(6);
    chk_bit(switchEn, 1'b0);
    tick(40);
    chk_bit(switchEn, 1'b1);
    // crossings shrink the span until lockout
    repeat (8) begin
      level = holdLevels.peak - 12'h001;
      tick(30);
      level = holdLevels.valley + 12'h001;
      tick(30);
    end
    chk_bit(switchEn, 1'b0);
    o = sliceOut;
    level = holdLevels.peak - 12'h001;
    tick(30);
    chk_bit(sliceOut, o);
    final_report();
  end
  // watchdog
  initial begin
    tick(20000);
    n_errors++;
    final_report();
  end
endmodule
bind gtps_slicer gtps_slicer_properties #(.LOCK_ON(LOCK_ON), .LOCK_OFF(LOCK_OFF)) u_props (
  .clk(clk), .reset_n(reset_n), .porActive(porActive), .sampleIn(sampleIn),
  .sliceOut(sliceOut), .holdLevels(holdLevels), .switchEn(switchEn));
